// *** rtl/cpu_bus_cycle_pkg.sv ***
// constants and types for the bus-cycle sequencer slice
package cpu_bus_cycle_pkg;
  localparam logic [7:0]  OPC_INDEX_TO_STACK = 8'h94;
  localparam logic [7:0]  OPC_WAIT           = 8'h8f;
  localparam logic [7:0]  VECTOR_PAGE        = 8'hff;
  localparam logic [7:0]  PAGE_ZERO_HIGH     = 8'h00;
  localparam logic [15:0] PC_RESET           = 16'h0000;
  localparam logic [15:0] SP_RESET           = 16'h00ff;
  localparam logic [15:0] INDEX_RESET        = 16'h0000;
  localparam logic        MASK_RESET         = 1'b1;

  // bus cycle kinds
  typedef enum logic [2:0] {
    CYC_FREE  = 3'b000,
    CYC_PROG  = 3'b001,
    CYC_READ  = 3'b010,
    CYC_WRITE = 3'b011,
    CYC_PUSH  = 3'b100,
    CYC_POP   = 3'b101,
    CYC_VECT  = 3'b110
  } cycle_kind_t;

  typedef enum logic [2:0] {
    ST_FETCH    = 3'b000,
    ST_XFER     = 3'b001,
    ST_WAITFREE = 3'b010,
    ST_HALTED   = 3'b011,
    ST_VECHI    = 3'b100,
    ST_VECLO    = 3'b101
  } seq_state_t;
endpackage

// *** rtl/cpu_bus_cycle_decode.sv ***
// bus-cycle sequencer: index-to-stack transfer, wait, operand address forms
//
// Summary of operation
// (RL1) stack pointer gets index pair minus one
// (RL2) wait clears mask, halts until interrupt
// (RL3) free cycle lasts one bus clock
// (RL4) free cycle always presents a read
// (RL5) program fetch reads next consecutive address
// (RL6) push writes one byte, pop reads one
// (RL7) vector read from top page, high first
// (RL8) relative offset signed, from next instruction
// (RL9) direct operand address high byte zero
// (RL10) short indexed offset is unsigned
// (RL11) halted: no fetches, resume via interrupt entry
`timescale 1ns/1ps
module cpu_bus_cycle_decode
  import cpu_bus_cycle_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              clkEn,
  // interrupt request (same clock domain)
  input  wire logic              irqReq,
  // system bus
  output logic [ADDR_W-1:0]      busAddr,
  output logic                   busRead,
  output logic                   busWrite,
  output logic [7:0]             busWdata,
  input  wire logic [7:0]        busRdata,
  output cycle_kind_t            busCycle,
  // operand address services
  input  wire logic [7:0]        operandByte,
  input  wire logic [ADDR_W-1:0] nextInstrAddr,
  input  wire logic [ADDR_W-1:0] indexPair,
  output logic [ADDR_W-1:0]      pageZeroAddr,
  output logic [ADDR_W-1:0]      shortIndexAddr,
  output logic [ADDR_W-1:0]      branchTarget,
  // stack access requests from the rest of the core
  input  wire logic              pushReq,
  input  wire logic              popReq,
  input  wire logic [7:0]        pushData,
  output logic [7:0]             popData,
  // core state
  output logic [ADDR_W-1:0]      stackPtr,
  output logic [ADDR_W-1:0]      progCnt,
  output logic                   intMask,
  output logic                   halted,
  output logic                   vectorDone
);

  initial begin
    if (ADDR_W != 16) begin
      $error("cpu_bus_cycle_decode supports only ADDR_W of 16");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    seq_state_t        state;
    logic [15:0]       pc;
    logic [15:0]       sp;
    logic              mask;
    logic [15:0]       addr;
    logic              rd;
    logic              wr;
    logic [7:0]        wdata;
    cycle_kind_t       kind;
    logic [7:0]        popData;
    logic [7:0]        vecHigh;
    logic              vecDone;
    logic [15:0]       pz;
    logic [15:0]       ix;
    logic [15:0]       br;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;

  // sign-extend a byte to address width
  function automatic logic [15:0] sext8(input logic [7:0] b);
    sext8 = {{8{b[7]}}, b};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cur_nxt         = cur_r;
    cur_nxt.vecDone = 1'b0;
    cur_nxt.pz      = {PAGE_ZERO_HIGH, operandByte};        // RL9
    cur_nxt.ix      = indexPair + {8'h00, operandByte};     // RL10
    cur_nxt.br      = nextInstrAddr + sext8(operandByte);   // RL8
    // default bus presentation: idle read, never a stray write
    cur_nxt.rd      = 1'b1;
    cur_nxt.wr      = 1'b0;
    cur_nxt.kind    = CYC_FREE;
    cur_nxt.addr    = cur_r.pc;
    unique case (cur_r.state)
      ST_FETCH: begin
        if (pushReq) begin
          cur_nxt.kind  = CYC_PUSH;                         // RL6
          cur_nxt.addr  = cur_r.sp;
          cur_nxt.rd    = 1'b0;
          cur_nxt.wr    = 1'b1;
          cur_nxt.wdata = pushData;
          cur_nxt.sp    = cur_r.sp - 16'h0001;
        end else if (popReq) begin
          cur_nxt.kind  = CYC_POP;                          // RL6
          cur_nxt.addr  = cur_r.sp + 16'h0001;
          cur_nxt.sp    = cur_r.sp + 16'h0001;
        end else begin
          cur_nxt.kind  = CYC_PROG;                         // RL5
          cur_nxt.addr  = cur_r.pc;
          cur_nxt.pc    = cur_r.pc + 16'h0001;
          if (cur_r.kind == CYC_PROG && busRdata == OPC_INDEX_TO_STACK) begin
            cur_nxt.kind  = CYC_FREE;                       // RL1
            cur_nxt.pc    = cur_r.pc;
            cur_nxt.state = ST_XFER;
          end else if (cur_r.kind == CYC_PROG && busRdata == OPC_WAIT) begin
            cur_nxt.kind  = CYC_FREE;                       // RL3 RL4
            cur_nxt.pc    = cur_r.pc;
            cur_nxt.mask  = 1'b0;                           // RL2
            cur_nxt.state = ST_WAITFREE;
          end
        end
        if (cur_r.kind == CYC_POP) begin
          cur_nxt.popData = busRdata;
        end
      end
      ST_XFER: begin
        // free cycle done; now the closing program fetch
        cur_nxt.sp    = indexPair - 16'h0001;               // RL1
        cur_nxt.kind  = CYC_PROG;                           // RL5
        cur_nxt.addr  = cur_r.pc;
        cur_nxt.pc    = cur_r.pc + 16'h0001;
        cur_nxt.state = ST_FETCH;
      end
      ST_WAITFREE: begin
        cur_nxt.kind  = CYC_PROG;                           // RL2
        cur_nxt.addr  = cur_r.pc;
        cur_nxt.state = ST_HALTED;
      end
      ST_HALTED: begin
        cur_nxt.kind = CYC_FREE;                            // RL11 RL4
        if (irqReq && !cur_r.mask) begin
          cur_nxt.kind  = CYC_VECT;                         // RL11 RL7
          cur_nxt.addr  = {VECTOR_PAGE, 8'hfa};
          cur_nxt.mask  = 1'b1;
          cur_nxt.state = ST_VECHI;
        end
      end
      ST_VECHI: begin
        cur_nxt.vecHigh = busRdata;                         // RL7
        cur_nxt.kind    = CYC_VECT;
        cur_nxt.addr    = {VECTOR_PAGE, 8'hfb};
        cur_nxt.state   = ST_VECLO;
      end
      ST_VECLO: begin
        cur_nxt.pc      = {cur_r.vecHigh, busRdata};        // RL7
        cur_nxt.vecDone = 1'b1;
        cur_nxt.kind    = CYC_FREE;
        cur_nxt.state   = ST_FETCH;
      end
      default: begin
        cur_nxt.state = ST_FETCH;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // one register per bus clock: each cycle kind holds exactly one period
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur_r         <= '0;
      cur_r.state   <= ST_FETCH;
      cur_r.pc      <= PC_RESET;
      cur_r.sp      <= SP_RESET;
      cur_r.ix      <= INDEX_RESET;
      cur_r.mask    <= MASK_RESET;
      cur_r.rd      <= 1'b1;
      cur_r.kind    <= CYC_FREE;
    end else if (clkEn) begin
      cur_r <= cur_nxt;                                     // RL3
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign busAddr        = cur_r.addr;
  assign busRead        = cur_r.rd;
  assign busWrite       = cur_r.wr;
  assign busWdata       = cur_r.wdata;
  assign busCycle       = cur_r.kind;
  assign popData        = cur_r.popData;
  assign pageZeroAddr   = cur_r.pz;
  assign shortIndexAddr = cur_r.ix;
  assign branchTarget   = cur_r.br;
  assign stackPtr       = cur_r.sp;
  assign progCnt        = cur_r.pc;
  assign intMask        = cur_r.mask;
  // the closing fetch of wait still stands in the first halted state cycle
  assign halted         = (cur_r.state == ST_HALTED) && (cur_r.kind != CYC_PROG);  // RL11
  assign vectorDone     = cur_r.vecDone;

endmodule

// *** bench/cpu_bus_cycle_monitor.sv ***
// port checker for the bus-cycle sequencer
`timescale 1ns/1ps
module cpu_bus_cycle_monitor
  import cpu_bus_cycle_pkg::*;
#(parameter int ADDR_W = 16) (
  // clock, reset, control
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              clkEn,
  input wire logic              irqReq,
  // bus
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic              busRead,
  input wire logic              busWrite,
  input wire cycle_kind_t       busCycle,
  // address forms and state
  input wire logic [7:0]        operandByte,
  input wire logic [ADDR_W-1:0] nextInstrAddr,
  input wire logic [ADDR_W-1:0] indexPair,
  input wire logic [ADDR_W-1:0] pageZeroAddr,
  input wire logic [ADDR_W-1:0] shortIndexAddr,
  input wire logic [ADDR_W-1:0] branchTarget,
  input wire logic              intMask,
  input wire logic              halted
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  chk_free_read: assert property (busCycle == CYC_FREE |-> busRead && !busWrite)
    else $error("free cycle not a read");
  chk_push_write: assert property (busCycle == CYC_PUSH |-> busWrite && !busRead)
    else $error("push cycle not a write");
  chk_prog_next: assert property ((busCycle == CYC_PROG && clkEn) ##1 busCycle == CYC_PROG
    |-> busAddr == $past(busAddr) + 16'h1) else $error("fetch address not consecutive");
  chk_vect_order: assert property (busCycle == CYC_VECT && busAddr == 16'hfffa && clkEn
    |=> busCycle == CYC_VECT && busAddr == {VECTOR_PAGE, 8'hfb}) else $error("vector order");
  chk_halt_quiet: assert property (halted |-> busCycle != CYC_PROG && !intMask)
    else $error("fetch or mask set while halted");
  // vector read follows in the next cycle; the bound leaves two cycles of slack
  chk_irq_resume: assert property (halted && irqReq && clkEn |-> ##[1:3] busCycle == CYC_VECT)
    else $error("no vector read after interrupt");
  chk_page_zero: assert property (clkEn |=> pageZeroAddr == {PAGE_ZERO_HIGH, $past(operandByte)})
    else $error("page zero address");
  chk_short_index: assert property (clkEn |=> shortIndexAddr == $past(indexPair) + {8'h00, $past(operandByte)})
    else $error("short index address");
  chk_branch_sext: assert property (clkEn |=> branchTarget == $past(nextInstrAddr)
    + {{8{$past(operandByte[7])}}, $past(operandByte)}) else $error("branch target");
endmodule
bind cpu_bus_cycle_decode cpu_bus_cycle_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// *** bench/bus_mem_model.sv ***
// program and data memory on the system bus
`timescale 1ns/1ps
module bus_mem_model (
  // bus
  input wire logic        clk_sys,
  input wire logic [15:0] busAddr,
  input wire logic        busRead,
  input wire logic        busWrite,
  input wire logic [7:0]  busWdata,
  output logic [7:0]      busRdata
);
  logic [7:0] mem [65536];
  initial begin
    foreach (mem[i]) mem[i] = 8'h9d;
    mem[0] = 8'h94;
    mem[1] = 8'h8f;
    mem[16'hfffa] = 8'h12;
    mem[16'hfffb] = 8'h34;
  end
  // data answers within the cycle the address stands, as the sequencer decodes it
  always @(posedge clk_sys) begin
    if (busWrite) mem[busAddr] <= busWdata;
  end
  // no read: flip the lines so a stale byte is never mistaken for data
  always_comb begin
    busRdata = busRead ? mem[busAddr] : ~mem[busAddr];
  end
endmodule

// *** bench/test_cpu_bus_cycle_decode.sv ***
// self-checking bench for the bus-cycle sequencer
`timescale 1ns/1ps
module test_cpu_bus_cycle_decode
  import cpu_bus_cycle_pkg::*;
;
  logic clk_sys = 1'b0, reset_n = 1'b0, clkEn = 1'b1, irqReq = 1'b0, pushReq = 1'b0, popReq = 1'b0;
  logic [7:0] operandByte = 8'h00, pushData = 8'ha5, busRdata, busWdata, popData;
  logic [15:0] nextInstrAddr = 16'h1000, indexPair = 16'h0100;
  logic [15:0] busAddr, stackPtr, progCnt, pageZeroAddr, shortIndexAddr, branchTarget;
  logic busRead, busWrite, intMask, halted, vectorDone;
  cycle_kind_t busCycle;
  int fails = 0, tests_run = 0, cycles = 0;
  always #50 clk_sys = ~clk_sys;
  cpu_bus_cycle_decode u_dut (.*);
  bus_mem_model u_mem (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic t_txs_wait;
    repeat (40) if (halted !== 1'b1) @(negedge clk_sys);
    chk("halted", 16'h1, {15'h0, halted});
    chk("stackPtr", indexPair - 16'h1, stackPtr);
    chk("intMask", 16'h0, {15'h0, intMask});
  endtask
  task automatic t_irq;
    clkEn = 1'b0;
    repeat (3) @(negedge clk_sys);
    clkEn = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("still halted", 16'h1, {15'h0, halted});
    irqReq = 1'b1;
    repeat (40) if (vectorDone !== 1'b1) @(negedge clk_sys);
    irqReq = 1'b0;
    chk("progCnt", 16'h1234, progCnt);
    chk("resumed", 16'h0, {15'h0, halted});
  endtask
  task automatic t_stack;
    pushReq = 1'b1;
    repeat (40) if (busCycle !== CYC_PUSH) @(negedge clk_sys);
    pushReq = 1'b0;
    chk("pushAddr", 16'h00ff, busAddr);
    chk("pushData", 16'h00a5, {8'h00, busWdata});
    popReq = 1'b1;
    repeat (40) if (busCycle !== CYC_POP) @(negedge clk_sys);
    popReq = 1'b0;
    chk("popAddr", 16'h00ff, busAddr);
    repeat (3) @(negedge clk_sys);
    chk("popData", 16'h00a5, {8'h00, popData});
    chk("stackBack", 16'h00ff, stackPtr);
  endtask
  task automatic t_addr;
    logic [7:0] ob [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    foreach (ob[i]) begin
      operandByte = ob[i];
      @(negedge clk_sys);
      chk("pageZero", {8'h00, ob[i]}, pageZeroAddr);
      chk("shortIndex", indexPair + {8'h00, ob[i]}, shortIndexAddr);
      chk("branch", nextInstrAddr + {{8{ob[i][7]}}, ob[i]}, branchTarget);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    t_txs_wait;
    t_irq;
    t_stack;
    t_addr;
    tally_and_finish;
  end
endmodule
